// ==== include/pcl_pkg.sv ====
/*
   Shared constants and carrier types for the peripheral card serial link.
   Assumes a single mclk domain inside the card; link pins are synchronised
   before use by the consumer of this package.
*/
package pcl_pkg;
   // payload limits and the register number that reads back the error byte
   localparam logic [3:0] PAYLOAD_MAX = 4'hF;
   localparam logic [3:0] COMM_REG = 4'hF;
   // command byte layout: read flag, echo flag, register number in [3:0]
   localparam int CMD_READ_BIT = 7;
   localparam int CMD_ECHO_BIT = 6;
   // status byte layout
   localparam logic [1:0] ST_READY = 2'h1;
   localparam logic [1:0] ST_BUSY = 2'h2;
   localparam int ST_ROUTER_BIT = 5;
   localparam int ST_COMM_BIT = 4;
   localparam int ST_NOEXEC_BIT = 1;
   localparam int ST_WDT_BIT = 0;
   localparam logic [7:0] STATUS_RST = 8'h40;
   // communication error byte layout
   localparam int CE_WAIT_BIT = 7;
   localparam int CE_COLL_BIT = 6;
   localparam int CE_OVR_BIT = 5;
   localparam int CE_MODE_BIT = 4;
   localparam int CE_CMP_BIT = 3;
   localparam logic [7:0] COMM_RST = 8'h00;
   // mclk cycles from byte end until the next transmit byte is loaded
   localparam logic [1:0] LOAD_DELAY = 2'h2;

   typedef enum logic [1:0] {
      PH_IDLE = 2'h0,
      PH_ADDR = 2'h1,
      PH_CMD = 2'h3,
      PH_DATA = 2'h2
   } pcl_phase_e;

   // one payload byte with its register number and position
   typedef struct packed {
      logic [3:0] regno;
      logic [3:0] idx;
      logic [7:0] data;
   } pcl_rx_s;

   // whole state of the link engine
   typedef struct packed {
      pcl_phase_e phase;
      logic sclk_d;
      logic [2:0] bitcnt;
      logic [7:0] rx_sh;
      logic [7:0] tx_sh;
      logic miso;
      logic sel;
      logic addr_ok;
      logic [7:0] cmd;
      logic [3:0] idx;
      logic [7:0] last_rx;
      logic [1:0] load_cnt;
      logic noexec;
      logic rx_valid;
      pcl_rx_s rx;
      logic [7:0] comm;
      logic [7:0] status;
   } pcl_link_s;
endpackage

// ==== logic/pcl_sync.sv ====
/*
   Two-stage synchroniser for a bundle of independent level signals.
   Assumes each bit is a slow level; no bus coherence is implied.
*/
`timescale 1ns/1ps
module pcl_sync #(
   parameter int W = 3
) (
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s2;
      logic [W-1:0] s1;
   } pcl_sync_s;

   pcl_sync_s st_ff;
   pcl_sync_s nxt_st;

   // first stage is read only by the second
   always_comb begin
      nxt_st.s1 = d;
      nxt_st.s2 = st_ff.s1;
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         st_ff <= '1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign q = st_ff.s2;
endmodule

// ==== logic/pcl_regmem.sv ====
/*
   Read-back byte store: one write port for the card logic, one registered
   read port for the link. Assumes both ports run on mclk.
*/
`timescale 1ns/1ps
module pcl_regmem #(
   parameter int AW = 8,
   parameter int DW = 8
) (
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [DW-1:0] wdata,
   input wire logic [AW-1:0] raddr,
   output logic [DW-1:0] rdata
);
   logic [DW-1:0] mem [2**AW];
   logic [DW-1:0] rdata_ff;

   // storage has no reset; unwritten bytes read as whatever was left
   always_ff @(posedge mclk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   // registered read, one cycle after the address
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rdata_ff <= '0;
      end else begin
         rdata_ff <= mem[raddr];
      end
   end

   assign rdata = rdata_ff;
endmodule

// ==== logic/pcl_link.sv ====
/*
   Card end of the point-to-point serial link: select, clock and data pins
   from the master, status and error bytes, echo, register read and write.
   Assumes the master's clock is far slower than mclk (eight or more mclk
   per half period) and that pins come straight from the line receivers.
   // Operation
   // - first byte addresses the card
   // - card selected at once on select
   // - deselected card ignores clock and data
   // - each clock moves one bit both ways
   // - select held whole command; release ends it
   // - write: register byte, then 0-15 bytes
   // - read: register byte, card returns 0-15 bytes
   // - zero length sends register byte only
   // - echo returns the byte the master sent
   // - status byte reports the previous command
   // - status fields: state, router, error, unexecuted, watchdog
   // - error byte, cleared on read
*/
`timescale 1ns/1ps
module pcl_link (
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic sclk,
   input wire logic ss_n,
   input wire logic mosi,
   output logic miso,
   input wire logic [7:0] card_addr,
   input wire logic busy,
   input wire logic wdt_expired,
   input wire logic usr_we,
   input wire pcl_pkg::pcl_rx_s usr_wr,
   output logic selected,
   output logic rx_valid,
   output pcl_pkg::pcl_rx_s rx,
   output logic [7:0] status,
   output logic [7:0] comm_err
);
   pcl_pkg::pcl_link_s st_ff;
   pcl_pkg::pcl_link_s nxt_st;
   logic sclk_s;
   logic ss_n_s;
   logic mosi_s;
   logic [7:0] rdata;
   logic [7:0] byte_in;
   logic rise;
   logic fall;
   logic done;
   logic ld;
   logic is_rd;
   logic is_echo;
   logic [7:0] ce_set;
   logic ce_clr;

   // status byte as sent at the head of a transaction
   function automatic logic [7:0] status_byte(input logic bsy, input logic err,
                                              input logic nox, input logic wdt);
      logic [7:0] s;
      s = 8'h00;
      s[7:6] = bsy ? pcl_pkg::ST_BUSY : pcl_pkg::ST_READY;
      s[pcl_pkg::ST_ROUTER_BIT] = 1'b0;
      s[pcl_pkg::ST_COMM_BIT] = err;
      s[pcl_pkg::ST_NOEXEC_BIT] = nox;
      s[pcl_pkg::ST_WDT_BIT] = wdt;
      return s;
   endfunction

   // link pins cross into mclk; the clock is only sampled, never used as one
   pcl_sync #(.W(3)) u_sync (
      .mclk(mclk),
      .arst_n(arst_n),
      .d({sclk, ss_n, mosi}),
      .q({sclk_s, ss_n_s, mosi_s})
   );

   // read-back bytes addressed by register number and payload position
   pcl_regmem #(.AW(8), .DW(8)) u_mem (
      .mclk(mclk),
      .arst_n(arst_n),
      .we(usr_we),
      .waddr({usr_wr.regno, usr_wr.idx}),
      .wdata(usr_wr.data),
      .raddr({st_ff.cmd[3:0], st_ff.idx}),
      .rdata(rdata)
   );

   // edge finding on the sampled clock
   assign byte_in = {st_ff.rx_sh[6:0], mosi_s};
   assign rise = sclk_s & ~st_ff.sclk_d;
   assign fall = ~sclk_s & st_ff.sclk_d;
   assign done = st_ff.sel & ~ss_n_s & rise & (st_ff.bitcnt == 3'h7);
   assign ld = st_ff.sel & ~ss_n_s & (st_ff.load_cnt == 2'h1);
   assign is_rd = st_ff.cmd[pcl_pkg::CMD_READ_BIT];
   assign is_echo = st_ff.cmd[pcl_pkg::CMD_ECHO_BIT];

   // next state of the whole engine
   always_comb begin
      nxt_st = st_ff;
      ce_set = 8'h00;
      ce_clr = 1'b0;
      nxt_st.sclk_d = sclk_s;
      nxt_st.rx_valid = 1'b0;
      // a card write while the master is on the line is a collision
      if (usr_we && st_ff.sel) begin
         ce_set[pcl_pkg::CE_COLL_BIT] = 1'b1;
      end
      if (ss_n_s) begin
         // release ends the transaction and fixes the next status
         if (st_ff.sel) begin
            nxt_st.noexec = ~st_ff.addr_ok | (st_ff.phase != pcl_pkg::PH_DATA)
                            | (is_rd & is_echo);
            if (st_ff.bitcnt != 3'h0) begin
               ce_set[pcl_pkg::CE_MODE_BIT] = 1'b1;
            end
         end
         nxt_st.sel = 1'b0;
         nxt_st.phase = pcl_pkg::PH_IDLE;
         nxt_st.load_cnt = 2'h0;
      end else if (!st_ff.sel) begin
         // selected on the select level alone, before any clock
         nxt_st.sel = 1'b1;
         nxt_st.phase = pcl_pkg::PH_ADDR;
         nxt_st.bitcnt = 3'h0;
         nxt_st.idx = 4'h0;
         nxt_st.addr_ok = 1'b0;
         nxt_st.cmd = 8'h00;
         // previous outcome goes out first, msb already on the pin
         nxt_st.status = status_byte(busy, |st_ff.comm, st_ff.noexec,
                                     wdt_expired);
         nxt_st.miso = nxt_st.status[7];
         nxt_st.tx_sh = {nxt_st.status[6:0], 1'b0};
      end else begin
         // sample on the rising edge, msb first
         if (rise) begin
            nxt_st.rx_sh = byte_in;
            nxt_st.bitcnt = st_ff.bitcnt + 3'h1;
         end
         // launch the next bit on the falling edge
         if (fall) begin
            nxt_st.miso = st_ff.tx_sh[7];
            nxt_st.tx_sh = {st_ff.tx_sh[6:0], 1'b0};
         end
         if (done) begin
            nxt_st.load_cnt = pcl_pkg::LOAD_DELAY;
            unique case (st_ff.phase)
               pcl_pkg::PH_ADDR: begin
                  // a byte that is not ours is a compare error
                  nxt_st.addr_ok = (byte_in == card_addr);
                  ce_set[pcl_pkg::CE_CMP_BIT] = (byte_in != card_addr);
                  nxt_st.phase = pcl_pkg::PH_CMD;
               end
               pcl_pkg::PH_CMD: begin
                  // register byte alone is a complete zero length command
                  nxt_st.cmd = byte_in;
                  nxt_st.phase = pcl_pkg::PH_DATA;
               end
               pcl_pkg::PH_DATA: begin
                  nxt_st.last_rx = byte_in;
                  // error byte clears only once its slot has gone out, so a
                  // zero length read keeps it; errors raised meanwhile go too
                  if (st_ff.addr_ok && is_rd && !is_echo && st_ff.idx == 4'h0
                      && st_ff.cmd[3:0] == pcl_pkg::COMM_REG) begin
                     ce_clr = 1'b1;
                  end
                  if (st_ff.idx == pcl_pkg::PAYLOAD_MAX) begin
                     ce_set[pcl_pkg::CE_OVR_BIT] = 1'b1;
                  end else begin
                     nxt_st.idx = st_ff.idx + 4'h1;
                     if (st_ff.addr_ok && !is_rd && !is_echo) begin
                        nxt_st.rx_valid = 1'b1;
                        nxt_st.rx = '{regno: st_ff.cmd[3:0], idx: st_ff.idx,
                                      data: byte_in};
                        ce_set[pcl_pkg::CE_WAIT_BIT] = 1'b1;
                     end
                  end
               end
               pcl_pkg::PH_IDLE: begin
                  nxt_st.phase = st_ff.phase;
               end
            endcase
         end
         if (st_ff.load_cnt != 2'h0) begin
            nxt_st.load_cnt = st_ff.load_cnt - 2'h1;
         end
         // memory data is ready two cycles after the byte ends
         if (ld) begin
            nxt_st.tx_sh = 8'h00;
            if (st_ff.phase == pcl_pkg::PH_DATA && st_ff.addr_ok) begin
               if (is_echo && !is_rd) begin
                  if (st_ff.idx != 4'h0) begin
                     nxt_st.tx_sh = st_ff.last_rx;
                  end
               end else if (is_rd && !is_echo && st_ff.idx != pcl_pkg::PAYLOAD_MAX) begin
                  if (st_ff.cmd[3:0] == pcl_pkg::COMM_REG) begin
                     if (st_ff.idx == 4'h0) begin
                        nxt_st.tx_sh = st_ff.comm;
                     end
                  end else begin
                     nxt_st.tx_sh = rdata;
                  end
               end
            end
         end
      end
      // a new error in the clearing cycle survives the clear
      nxt_st.comm = (ce_clr ? 8'h00 : st_ff.comm) | ce_set;
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         st_ff <= '0;
         st_ff.sclk_d <= 1'b0;
         st_ff.comm <= pcl_pkg::COMM_RST;
         st_ff.status <= pcl_pkg::STATUS_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // outputs straight from the state register
   assign miso = st_ff.miso;
   assign selected = st_ff.sel;
   assign rx_valid = st_ff.rx_valid;
   assign rx = st_ff.rx;
   assign status = st_ff.status;
   assign comm_err = st_ff.comm;

   // checks of the engine against its pins
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!arst_n);

   property p_sel_now;
      !ss_n_s |=> st_ff.sel;
   endproperty
   a_sel_now: assert property (p_sel_now) else $error("select not taken");

   property p_desel;
      ss_n_s |=> !st_ff.sel && st_ff.phase == pcl_pkg::PH_IDLE;
   endproperty
   a_desel: assert property (p_desel) else $error("release did not end");

   property p_ignore;
      ss_n_s ##1 ss_n_s |-> !st_ff.rx_valid;
   endproperty
   a_ignore: assert property (p_ignore) else $error("data while idle");

   property p_head_status;
      $rose(st_ff.sel) |-> st_ff.miso == st_ff.status[7]
         && st_ff.status[pcl_pkg::ST_NOEXEC_BIT] == $past(st_ff.noexec);
   endproperty
   a_head_status: assert property (p_head_status) else $error("bad head");

   property p_bit_in;
      st_ff.sel && !ss_n_s && rise |=> st_ff.bitcnt == $past(st_ff.bitcnt) + 3'h1
         && st_ff.rx_sh[0] == $past(mosi_s);
   endproperty
   a_bit_in: assert property (p_bit_in) else $error("bit not taken");

   property p_bit_out;
      st_ff.sel && !ss_n_s && fall |=> st_ff.miso == $past(st_ff.tx_sh[7]);
   endproperty
   a_bit_out: assert property (p_bit_out) else $error("bit not launched");

   property p_addr;
      done && st_ff.phase == pcl_pkg::PH_ADDR && byte_in != card_addr
         |=> !st_ff.addr_ok && st_ff.comm[pcl_pkg::CE_CMP_BIT];
   endproperty
   a_addr: assert property (p_addr) else $error("foreign address taken");

   property p_wr_len;
      st_ff.rx_valid |-> st_ff.rx.idx < pcl_pkg::PAYLOAD_MAX && !is_rd
         && st_ff.idx == st_ff.rx.idx + 4'h1;
   endproperty
   a_wr_len: assert property (p_wr_len) else $error("bad write byte");

   property p_echo;
      ld && st_ff.phase == pcl_pkg::PH_DATA && st_ff.addr_ok && is_echo && !is_rd
         && st_ff.idx != 4'h0 |=> st_ff.tx_sh == $past(st_ff.last_rx);
   endproperty
   a_echo: assert property (p_echo) else $error("echo mismatch");

   property p_comm_read;
      ld && st_ff.phase == pcl_pkg::PH_DATA && st_ff.addr_ok && is_rd && !is_echo
         && st_ff.cmd[3:0] == pcl_pkg::COMM_REG && st_ff.idx == 4'h0
         |=> st_ff.tx_sh == $past(st_ff.comm);
   endproperty
   a_comm_read: assert property (p_comm_read) else $error("error byte lost");

   property p_fields;
      st_ff.sel |-> st_ff.status[7:6] != 2'h0 && !st_ff.status[pcl_pkg::ST_ROUTER_BIT];
   endproperty
   a_fields: assert property (p_fields) else $error("bad status fields");

   c_write: cover property (st_ff.rx_valid);
   c_echo: cover property (ld && is_echo && st_ff.idx != 4'h0);
   c_overrun: cover property ($rose(st_ff.comm[pcl_pkg::CE_OVR_BIT]));
   c_mode: cover property ($rose(st_ff.comm[pcl_pkg::CE_MODE_BIT]));
   c_noexec: cover property ($rose(st_ff.noexec));
endmodule

// ==== testbench/pcl_master.sv ====
/*
   Behavioural master controller for the card link: makes the serial clock
   and select, shifts command bytes out and collects the reply bytes.
   Assumes the bench calls its tasks one at a time and owns mclk.
*/
`timescale 1ns/1ps
module pcl_master (
   input wire logic mclk,
   output logic sclk,
   output logic ss_n,
   output logic mosi,
   input wire logic miso
);
   logic [7:0] tx_buf [0:17];
   logic [7:0] rx_buf [0:17];

   // clock parked low, card deselected
   initial begin
      sclk = 1'b0;
      ss_n = 1'b1;
      mosi = 1'b0;
   end

   // all pin changes land just after an mclk rise
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask

   // released data line shows the inverse of its last bit
   task automatic sel(input logic lvl);
      ss_n = lvl;
      if (lvl) begin
         mosi = ~mosi;
      end
      tick(8);
   endtask

   // mode 0: data set on the fall, both sides sample on the rise
   task automatic shift(input logic [7:0] tx, output logic [7:0] rx, input int nb);
      rx = 8'h00;
      for (int i = 0; i < nb; i++) begin
         mosi = tx[7-i];
         tick(16);
         sclk = 1'b1;
         rx = {rx[6:0], miso};
         tick(16);
         sclk = 1'b0;
      end
   endtask

   // clocks and data wiggling with select high; only for ignore checks
   task automatic idle(input int n);
      for (int i = 0; i < n; i++) begin
         sclk = 1'b1;
         mosi = ~mosi;
         tick(16);
         sclk = 1'b0;
         tick(16);
      end
   endtask

   // one whole frame; buffer caps length at address, command and 16 bytes
   task automatic frame(input int n, input int cut);
      sel(1'b0);
      for (int k = 0; k < n; k++) begin
         shift(tx_buf[k], rx_buf[k], (k == n - 1) ? cut : 8);
      end
      tick(4);
      sel(1'b1);
   endtask
endmodule

// ==== testbench/testbench.sv ====
/*
   Self-checking bench for the card link engine with one master model.
   Assumes the design's own assertions run alongside; no register bus.
*/
`timescale 1ns/1ps
module testbench;
   // node byte: master port 1, first router port 3, second router port 2
   localparam logic [7:0] ADDR = {2'h1, 3'h3, 3'h2};
   logic mclk, arst_n, sclk, ss_n, mosi, miso, busy, wdt_expired, usr_we;
   logic selected, rx_valid;
   logic [7:0] card_addr, status, comm_err, rb;
   pcl_pkg::pcl_rx_s usr_wr, rx;
   pcl_pkg::pcl_rx_s log_q [0:31];
   int fail_count, cmp_count, nrx, cyc;

   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   // one master port wired straight to one card, no router between
   pcl_master pcl_master_i (.mclk(mclk), .sclk(sclk), .ss_n(ss_n), .mosi(mosi), .miso(miso));

   pcl_link pcl_link_i (.mclk(mclk), .arst_n(arst_n), .sclk(sclk), .ss_n(ss_n),
      .mosi(mosi), .miso(miso), .card_addr(card_addr), .busy(busy),
      .wdt_expired(wdt_expired), .usr_we(usr_we), .usr_wr(usr_wr),
      .selected(selected), .rx_valid(rx_valid), .rx(rx), .status(status),
      .comm_err(comm_err));

   // payload log and hang guard; longest run is far under the ceiling
   always @(posedge mclk) begin
      cyc++;
      if (rx_valid === 1'b1 && nrx < 32) begin
         log_q[nrx] = rx;
         nrx++;
      end
      if (cyc == 40000) begin
         fail_count++;
         summarize();
      end
   end

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask

   task automatic put3(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
      pcl_master_i.tx_buf[0] = a;
      pcl_master_i.tx_buf[1] = b;
      pcl_master_i.tx_buf[2] = c;
   endtask

   // card-side store write, one strobe cycle
   task automatic wr(input logic [3:0] r, input logic [3:0] i, input logic [7:0] d);
      usr_wr = '{regno: r, idx: i, data: d};
      usr_we = 1'b1;
      tick(1);
      usr_we = 1'b0;
      tick(1);
   endtask

   task automatic t_reset();
      chk(status, 8'h40);
      chk(comm_err, 8'h00);
      chk({7'h00, selected}, 8'h00);
      chk({7'h00, miso}, 8'h00);
      $display("test reset done");
   endtask

   task automatic t_ignore();
      pcl_master_i.idle(10);
      chk(8'(nrx), 8'h00);
      chk({7'h00, selected}, 8'h00);
      chk(comm_err, 8'h00);
      $display("test ignore done");
   endtask

   // fifteen bytes stored, sixteenth dropped as overrun
   task automatic t_write();
      put3(ADDR, 8'h03, 8'h00);
      for (int k = 1; k < 16; k++) begin
         pcl_master_i.tx_buf[k+2] = 8'(k * 17);
      end
      pcl_master_i.frame(18, 8);
      chk(pcl_master_i.rx_buf[0] & 8'hC3, 8'h40);
      for (int k = 1; k < 18; k++) begin
         chk(pcl_master_i.rx_buf[k], 8'h00);
      end
      chk(8'(nrx), 8'h0F);
      for (int k = 0; k < 15; k++) begin
         chk({log_q[k].regno, log_q[k].idx}, {4'h3, 4'(k)});
         chk(log_q[k].data, 8'(k * 17));
      end
      chk(comm_err, 8'hA0);
      $display("test write done");
   endtask

   task automatic t_status();
      busy = 1'b1;
      wdt_expired = 1'b1;
      put3(ADDR, 8'h8F, 8'h00);
      pcl_master_i.frame(3, 8);
      chk(pcl_master_i.rx_buf[0] & 8'hF3, 8'h91);
      chk(status, 8'h91);
      chk(pcl_master_i.rx_buf[2], 8'hA0);
      chk(comm_err, 8'h00);
      busy = 1'b0;
      wdt_expired = 1'b0;
      $display("test status done");
   endtask

   task automatic t_addr();
      put3(ADDR ^ 8'hFF, 8'h02, 8'h77);
      pcl_master_i.frame(3, 8);
      chk(pcl_master_i.rx_buf[1], 8'h00);
      chk(pcl_master_i.rx_buf[2], 8'h00);
      chk(8'(nrx), 8'h0F);
      chk(comm_err, 8'h08);
      put3(ADDR, 8'h8F, 8'h00);
      pcl_master_i.frame(2, 8);
      chk(pcl_master_i.rx_buf[0] & 8'hF3, 8'h52);
      chk(comm_err, 8'h08);
      $display("test address done");
   endtask

   task automatic t_echo();
      put3(ADDR, 8'h40, 8'h55);
      pcl_master_i.tx_buf[3] = 8'hAA;
      pcl_master_i.tx_buf[4] = 8'h0F;
      pcl_master_i.frame(5, 8);
      chk(pcl_master_i.rx_buf[0] & 8'h03, 8'h00);
      chk(pcl_master_i.rx_buf[2], 8'h00);
      chk(pcl_master_i.rx_buf[3], 8'h55);
      chk(pcl_master_i.rx_buf[4], 8'hAA);
      // read and echo together is refused: nothing returned or stored
      put3(ADDR, 8'hC0, 8'h11);
      pcl_master_i.frame(3, 8);
      chk(pcl_master_i.rx_buf[0] & 8'h03, 8'h00);
      chk(pcl_master_i.rx_buf[2], 8'h00);
      chk(8'(nrx), 8'h0F);
      $display("test echo done");
   endtask

   task automatic t_read();
      wr(4'h5, 4'h0, 8'hC3);
      wr(4'h5, 4'h1, 8'h3C);
      put3(ADDR, 8'h85, 8'h00);
      pcl_master_i.tx_buf[3] = 8'h00;
      pcl_master_i.frame(4, 8);
      chk(pcl_master_i.rx_buf[0] & 8'h03, 8'h02);
      chk(pcl_master_i.rx_buf[2], 8'hC3);
      chk(pcl_master_i.rx_buf[3], 8'h3C);
      chk(comm_err, 8'h08);
      $display("test read done");
   endtask

   // store write while selected, then select dropped after three bits
   task automatic t_abort();
      pcl_master_i.sel(1'b0);
      chk({7'h00, selected}, 8'h01);
      wr(4'h5, 4'h2, 8'h99);
      pcl_master_i.shift(ADDR, rb, 3);
      pcl_master_i.sel(1'b1);
      chk({7'h00, selected}, 8'h00);
      chk(comm_err, 8'h58);
      put3(ADDR, 8'h8F, 8'h00);
      pcl_master_i.frame(3, 8);
      chk(pcl_master_i.rx_buf[2], 8'h58);
      chk(comm_err, 8'h00);
      $display("test abort done");
   endtask

   initial begin
      fail_count = 0;
      cmp_count = 0;
      nrx = 0;
      cyc = 0;
      arst_n = 1'b0;
      card_addr = ADDR;
      busy = 1'b0;
      wdt_expired = 1'b0;
      usr_we = 1'b0;
      usr_wr = '0;
      tick(10);
      t_reset();
      arst_n = 1'b1;
      tick(4);
      t_ignore();
      t_write();
      t_status();
      t_addr();
      t_echo();
      t_read();
      t_abort();
      summarize();
   end
endmodule
